// [lmc_ctrl.sv]
// Link mode control register with APB slave, data gating and loopback
// How it works
// RULE1: disconnect bit holds link logically disconnected
// RULE2: no DMA transfer while disconnect set
// RULE3: reset sets the disconnect bit
// RULE4: no transmit or receive until cleared
// RULE5: accept information frames only when ready
// RULE6: loopback routes transmit data into receiver
// RULE7: loopback ignores receive data and clock pins
// RULE8: host makes both address fields equal first
// RULE9: active bit with disconnect clear starts setup
// RULE10: passive mode waits for remote setup
// RULE11: DISC exchange precedes SABM when bit clear
// RULE12: bit set sends SABM only
// RULE13: bit 5 selects half or full duplex
// RULE14: bit 2 register test, bit 6 zero
// RULE15: host writes address fields while disconnected
module lmc_ctrl
   import lmc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        TXD_IN,
   input  wire logic        TX_BIT_EN,
   input  wire logic        RXD_PIN,
   input  wire logic        RXC_PIN,
   output logic             RX_DATA,
   output logic             RX_BIT_EN,
   input  wire logic        DMA_REQ,
   output logic             DMA_REQ_OUT,
   output logic             TX_EN,
   output logic             RX_EN,
   output logic             IFRAME_RX_EN,
   output logic             LINK_DISC,
   output logic             REG_TEST,
   output logic             HALF_DUPLEX,
   input  wire logic        FRAME_ACK,
   input  wire logic        REMOTE_SABM,
   output logic             SEND_DISC,
   output logic             SEND_SABM,
   output logic             LINK_UP
);
   import lmc_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0]  ctrl_reg;     // Control word
   logic [7:0]  ctrl_next;    // Control after write
   logic        access;       // Completing APB access
   logic        hit_ctrl;     // Control address
   logic        hit_stat;     // Status address
   logic [31:0] rdata_next;   // Read data mux
   lmc_link_if  lnk ();       // Link to sequencer

   // Named control fields
   wire mandatory_disconnect  = ctrl_reg[LMC_B_MANDATORY_DISCONNECT];
   wire rbrdy  = ctrl_reg[LMC_B_RBRDY];
   wire loop   = ctrl_reg[LMC_B_LOOP];

   // ****************************************
   // APB decode
   // ****************************************
   // Write takes effect only at the ready edge; read data is captured at setup
   assign access   = PSEL && PENABLE && PREADY;
   assign hit_ctrl = (PADDR == LMC_CTRL_ADDR);
   assign hit_stat = (PADDR == LMC_STAT_ADDR);
   assign ctrl_next = PWDATA[7:0] & LMC_CTRL_WMSK; // RULE14

   // Read data selection
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_ctrl) begin
         rdata_next[7:0] = ctrl_reg;
      end else if (hit_stat) begin
         rdata_next[6:0] = lnk.state;
         rdata_next[8]   = LINK_UP;
      end
   end

   // Ready one cycle after setup: no wait states
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
      end
   end

   // Read data and error captured at setup
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_next;
         // Unmapped address, or write to status
         PSLVERR <= !(hit_ctrl || (hit_stat && !PWRITE));
      end else begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   // Reset leaves the link disconnected
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_reg <= LMC_CTRL_RST; // RULE3
      end else if (access && PWRITE && hit_ctrl) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ****************************************
   // Data path gating
   // ****************************************
   // Transfers, transmit and receive held off while disconnected
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DMA_REQ_OUT  <= 1'b0;
         TX_EN        <= 1'b0;
         RX_EN        <= 1'b0;
         IFRAME_RX_EN <= 1'b0;
         LINK_DISC    <= 1'b1;
      end else begin
         DMA_REQ_OUT  <= DMA_REQ && !mandatory_disconnect; // RULE2
         TX_EN        <= !mandatory_disconnect; // RULE4
         RX_EN        <= !mandatory_disconnect; // RULE4
         IFRAME_RX_EN <= !mandatory_disconnect && rbrdy; // RULE5
         LINK_DISC    <= mandatory_disconnect; // RULE1
      end
   end

   // ****************************************
   // Mode outputs
   // ****************************************
   // Duplex and register test selections
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         HALF_DUPLEX <= 1'b0;
         REG_TEST    <= 1'b0;
      end else begin
         HALF_DUPLEX <= ctrl_reg[LMC_B_HALF]; // RULE13
         REG_TEST    <= ctrl_reg[LMC_B_RTEST]; // RULE14
      end
   end

   // ****************************************
   // Loopback
   // ****************************************
   // Receiver fed from transmitter, pins not looked at
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RX_DATA   <= 1'b1;
         RX_BIT_EN <= 1'b0;
      end else if (loop) begin
         RX_DATA   <= TXD_IN; // RULE6
         RX_BIT_EN <= TX_BIT_EN; // RULE7
      end else begin
         RX_DATA   <= RXD_PIN;
         RX_BIT_EN <= RXC_PIN;
      end
   end

   // ****************************************
   // Link setup
   // ****************************************
   // Acknowledge frames are meaningless while disconnected
   assign lnk.mandatory_disconnect       = mandatory_disconnect;
   assign lnk.active      = ctrl_reg[LMC_B_ACTIVE];
   assign lnk.skip_disc   = ctrl_reg[LMC_B_SKIPD];
   assign lnk.ack_rx      = FRAME_ACK && !mandatory_disconnect;
   assign lnk.remote_sabm = REMOTE_SABM && !mandatory_disconnect;

   // Setup state machine
   lmc_setup_seq u_seq (
      .clk   (CLK),
      .rst_n (RST_N),
      .lnk   (lnk)
   );

   // Frame requests and link state from the sequencer
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SEND_DISC <= 1'b0;
         SEND_SABM <= 1'b0;
         LINK_UP   <= 1'b0;
      end else begin
         // Requests die at once if disconnect is set again
         SEND_DISC <= (lnk.state == LMC_SEND_DISC) && !mandatory_disconnect; // RULE11
         SEND_SABM <= (lnk.state == LMC_SEND_SABM) && !mandatory_disconnect; // RULE9
         LINK_UP   <= (lnk.state == LMC_LINKED) && !mandatory_disconnect; // RULE1
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_reset_disc: assert property ( // RULE3
      @(posedge CLK)
      !RST_N |=> mandatory_disconnect ##1 LINK_DISC)
      else $error("reset did not set disconnect");
   a_link_down: assert property ( // RULE1
      @(posedge CLK) disable iff (!RST_N)
      mandatory_disconnect |=> !LINK_UP && LINK_DISC && !SEND_DISC)
      else $error("link up while disconnected");
   a_dma_blocked: assert property ( // RULE2
      @(posedge CLK) disable iff (!RST_N)
      mandatory_disconnect |=> !DMA_REQ_OUT)
      else $error("DMA passed while disconnected");
   a_data_held: assert property ( // RULE4
      @(posedge CLK) disable iff (!RST_N)
      mandatory_disconnect |=> !TX_EN && !RX_EN)
      else $error("data enabled while disconnected");
   a_iframe_gate: assert property ( // RULE5
      @(posedge CLK) disable iff (!RST_N)
      (!rbrdy || mandatory_disconnect) |=> !IFRAME_RX_EN)
      else $error("I-frames accepted while not ready");
   a_loop_data: assert property ( // RULE6
      @(posedge CLK) disable iff (!RST_N)
      loop |=> RX_DATA == $past(TXD_IN))
      else $error("loopback data not routed");
   a_loop_pins: assert property ( // RULE7
      @(posedge CLK) disable iff (!RST_N)
      loop |=> RX_BIT_EN == $past(TX_BIT_EN))
      else $error("receive clock pin used in loopback");
   a_setup_start: assert property ( // RULE9
      @(posedge CLK) disable iff (!RST_N)
      (lnk.state == LMC_IDLE && !mandatory_disconnect && lnk.active && lnk.skip_disc)
      ##1 !mandatory_disconnect |=> SEND_SABM)
      else $error("active setup sent no SABM");
   a_duplex_sel: assert property ( // RULE13
      @(posedge CLK) disable iff (!RST_N)
      $changed(ctrl_reg[LMC_B_HALF]) |=> HALF_DUPLEX == $past(ctrl_reg[LMC_B_HALF]))
      else $error("duplex output wrong");
   a_test_bits: assert property ( // RULE14
      @(posedge CLK) disable iff (!RST_N)
      !ctrl_reg[6] && (REG_TEST == $past(ctrl_reg[LMC_B_RTEST])))
      else $error("test bit or unused bit wrong");
   a_apb_ready: assert property (
      @(posedge CLK) disable iff (!RST_N)
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
      else $error("APB ready not one cycle");

   // ****************************************
   // Checks of the open link and the register
   // ****************************************
   // Data path opens once disconnect is cleared
   a_enable_open: assert property ( // RULE4
      @(posedge CLK) disable iff (!RST_N)
      !mandatory_disconnect |=> TX_EN && RX_EN)
      else $error("data held although connected");
   // DMA request passes unchanged while connected
   a_dma_pass: assert property ( // RULE2
      @(posedge CLK) disable iff (!RST_N)
      !mandatory_disconnect |=> DMA_REQ_OUT == $past(DMA_REQ))
      else $error("DMA request lost while connected");
   // Ready receiver with open link takes I-frames
   a_iframe_open: assert property ( // RULE5
      @(posedge CLK) disable iff (!RST_N)
      (rbrdy && !mandatory_disconnect) |=> IFRAME_RX_EN)
      else $error("I-frames refused although ready");
   // Outside loopback the receive pins feed the receiver
   a_pins_used: assert property ( // RULE7
      @(posedge CLK) disable iff (!RST_N)
      !loop |=> RX_DATA == $past(RXD_PIN) && RX_BIT_EN == $past(RXC_PIN))
      else $error("receive pins not used");
   // A control write lands with bit 6 masked
   a_write_lands: assert property ( // RULE14
      @(posedge CLK) disable iff (!RST_N)
      (access && PWRITE && hit_ctrl) |=> ctrl_reg == $past(ctrl_next))
      else $error("control write lost");
   // Disconnect stays until software clears it
   a_disc_kept: assert property ( // RULE4
      @(posedge CLK) disable iff (!RST_N)
      (mandatory_disconnect && !(access && PWRITE && hit_ctrl)) |=> mandatory_disconnect)
      else $error("disconnect cleared without a write");
   // DISC frame requests are single pulses
   a_disc_pulse: assert property ( // RULE11
      @(posedge CLK) disable iff (!RST_N)
      SEND_DISC |=> !SEND_DISC)
      else $error("DISC request longer than one cycle");
   // No SABM request while disconnected
   a_no_sabm: assert property ( // RULE1
      @(posedge CLK) disable iff (!RST_N)
      mandatory_disconnect |=> !SEND_SABM)
      else $error("SABM requested while disconnected");
   // Link up only from the linked state
   a_link_state: assert property ( // RULE1
      @(posedge CLK) disable iff (!RST_N)
      LINK_UP |-> $past(lnk.state == LMC_LINKED))
      else $error("link up outside linked state");
   // Half duplex bit drives the duplex output
   a_half_sel: assert property ( // RULE13
      @(posedge CLK) disable iff (!RST_N)
      ctrl_reg[LMC_B_HALF] |=> HALF_DUPLEX)
      else $error("half duplex not selected");
   // Control read returns the stored word
   a_ctrl_read: assert property ( // RULE14
      @(posedge CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && hit_ctrl) |=> PRDATA[7:0] == $past(ctrl_reg))
      else $error("control read data wrong");
   // Unmapped setup answers with an error
   a_slverr_map: assert property (
      @(posedge CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !hit_ctrl && !hit_stat) |=> PSLVERR)
      else $error("unmapped access not refused");
endmodule

// [lmc_link_if.sv]
// Interface between the control register and the setup sequencer
interface lmc_link_if;
   import lmc_pkg::*;
   logic       mandatory_disconnect;        // Mandatory disconnect
   logic       active;       // Active setup selected
   logic       skip_disc;    // Skip DISC exchange
   logic       ack_rx;       // Acknowledge frame received
   logic       remote_sabm;  // Remote SABM received
   lmc_state_t state;        // Sequencer state
   modport ctrl (output mandatory_disconnect, active, skip_disc, ack_rx, remote_sabm, input state);
   modport seq  (input mandatory_disconnect, active, skip_disc, ack_rx, remote_sabm, output state);
endinterface

// [lmc_pkg.sv]
// Constants and types of the link mode control register block
package lmc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] LMC_CTRL_IDX  = 12'h000;  // Control word index
   localparam logic [11:0] LMC_CTRL_ADDR = {LMC_CTRL_IDX[9:0], 2'b00};
   localparam logic [11:0] LMC_STAT_ADDR = 12'h040;  // Setup status word
   // ****************************************
   // Control field positions
   // ****************************************
   localparam int LMC_B_MANDATORY_DISCONNECT  = 0;  // Mandatory disconnect
   localparam int LMC_B_RBRDY  = 1;  // Receive buffer ready
   localparam int LMC_B_RTEST  = 2;  // Internal register test
   localparam int LMC_B_LOOP   = 3;  // Loopback test
   localparam int LMC_B_ACTIVE = 4;  // Active link setup
   localparam int LMC_B_HALF   = 5;  // Half duplex
   localparam int LMC_B_SKIPD  = 7;  // Skip disconnect before setup
   // ****************************************
   // Reset value and writable bits
   // ****************************************
   localparam logic [7:0] LMC_CTRL_RST  = 8'h01;  // Disconnected
   localparam logic [7:0] LMC_CTRL_WMSK = 8'hBF;  // Bit 6 stays 0
   // ****************************************
   // Link setup states
   // ****************************************
   typedef enum logic [6:0] {
      LMC_IDLE      = 7'h01,  // Logically disconnected
      LMC_SEND_DISC = 7'h02,  // Request DISC frame
      LMC_WAIT_DISC = 7'h04,  // Await DISC acknowledge
      LMC_SEND_SABM = 7'h08,  // Request SABM frame
      LMC_WAIT_SABM = 7'h10,  // Await SABM acknowledge
      LMC_PASSIVE   = 7'h20,  // Await remote setup
      LMC_LINKED    = 7'h40   // Link established
   } lmc_state_t;
endpackage

// [lmc_remote.sv]
// Remote station model: acknowledges frames and opens the link on request
module lmc_remote (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       send_disc,
   input  wire logic       send_sabm,
   input  wire logic [3:0] ack_dly,
   input  wire logic       open_req,
   output logic            frame_ack,
   output logic            remote_sabm
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt;  // Cycles left before the acknowledge
   // ****************************************
   // Acknowledge each requested frame, promptly or late
   // ****************************************
   always_ff @(posedge clk) begin
      frame_ack <= 1'b0;
      if (!rst_n) begin
         cnt <= 5'h00;
      end else if (send_disc || send_sabm) begin
         cnt <= {1'b0, ack_dly} + 5'h01;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
         frame_ack <= (cnt == 5'h01);
      end
   end
   // Remote opens the link when the bench asks
   always_ff @(posedge clk) begin
      remote_sabm <= rst_n && open_req;
   end
endmodule

// [lmc_setup_seq.sv]
// Link setup sequencer for active and passive link establishment
module lmc_setup_seq
   import lmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   lmc_link_if.seq  lnk
);
   lmc_state_t state_reg;   // Current state
   lmc_state_t state_next;  // Next state

   assign lnk.state = state_reg;

   // ****************************************
   // State register
   // ****************************************
   // Synchronous reset to disconnected
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= LMC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      if (lnk.mandatory_disconnect) begin
         // Disconnect overrides any progress
         state_next = LMC_IDLE; // RULE1
      end else begin
         unique case (state_reg)
            LMC_IDLE: begin
               if (lnk.active && !lnk.skip_disc) begin
                  state_next = LMC_SEND_DISC; // RULE11
               end else if (lnk.active) begin
                  state_next = LMC_SEND_SABM; // RULE12
               end else begin
                  state_next = LMC_PASSIVE; // RULE10
               end
            end
            LMC_SEND_DISC: state_next = LMC_WAIT_DISC;
            LMC_WAIT_DISC: begin
               // SABM only after DISC is acknowledged
               if (lnk.ack_rx) begin
                  state_next = LMC_SEND_SABM; // RULE11
               end
            end
            LMC_SEND_SABM: state_next = LMC_WAIT_SABM;
            LMC_WAIT_SABM: begin
               if (lnk.ack_rx) begin
                  state_next = LMC_LINKED; // RULE9
               end
            end
            LMC_PASSIVE: begin
               // Remote station opens the link
               if (lnk.remote_sabm) begin
                  state_next = LMC_LINKED; // RULE10
               end
            end
            LMC_LINKED: state_next = LMC_LINKED;
            default: state_next = LMC_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_active_start: assert property ( // RULE9
      @(posedge clk) disable iff (!rst_n)
      (state_reg == LMC_IDLE && !lnk.mandatory_disconnect && lnk.active)
      |=> (state_reg == LMC_SEND_DISC || state_reg == LMC_SEND_SABM))
      else $error("active setup did not start");
   a_passive_wait: assert property ( // RULE10
      @(posedge clk) disable iff (!rst_n)
      (state_reg == LMC_IDLE && !lnk.mandatory_disconnect && !lnk.active)
      |=> state_reg == LMC_PASSIVE)
      else $error("passive mode did not wait");
   a_disc_first: assert property ( // RULE11
      @(posedge clk) disable iff (!rst_n)
      (state_reg == LMC_WAIT_DISC && !lnk.ack_rx && !lnk.mandatory_disconnect)
      |=> state_reg == LMC_WAIT_DISC)
      else $error("SABM before DISC acknowledge");
   a_sabm_only: assert property ( // RULE12
      @(posedge clk) disable iff (!rst_n)
      (state_reg == LMC_IDLE && !lnk.mandatory_disconnect && lnk.active && lnk.skip_disc)
      |=> state_reg == LMC_SEND_SABM)
      else $error("DISC sent although skipped");
endmodule

// [tb.sv]
// Self-checking testbench of the link mode control register
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); mismatches++; end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lmc_pkg::*;
   logic        CLK, PREADY, PSLVERR, RX_DATA, RX_BIT_EN, DMA_REQ_OUT, TX_EN, RX_EN;
   logic        IFRAME_RX_EN, LINK_DISC, REG_TEST, HALF_DUPLEX, FRAME_ACK, REMOTE_SABM;
   logic        SEND_DISC, SEND_SABM, LINK_UP;
   logic        RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic        TXD_IN = 1'b0, TX_BIT_EN = 1'b0, RXD_PIN = 1'b0, RXC_PIN = 1'b0;
   logic        DMA_REQ = 1'b1, OPEN_REQ = 1'b0;
   logic [3:0]  ACK_DLY = 4'h0;   // Partner acknowledge delay
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic [33:0] exp_q[$];        // Notes: {write, error, data}
   logic [7:0]  lg = 8'h00;      // Frame request log, 2 bits each
   int          mismatches = 0, tests_run = 0, cyc = 0;
   lmc_ctrl dut (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .TXD_IN, .TX_BIT_EN, .RXD_PIN, .RXC_PIN, .RX_DATA, .RX_BIT_EN,
      .DMA_REQ, .DMA_REQ_OUT, .TX_EN, .RX_EN, .IFRAME_RX_EN, .LINK_DISC, .REG_TEST,
      .HALF_DUPLEX, .FRAME_ACK, .REMOTE_SABM, .SEND_DISC, .SEND_SABM, .LINK_UP);
   lmc_remote rem (.clk(CLK), .rst_n(RST_N), .send_disc(SEND_DISC), .send_sabm(SEND_SABM),
      .ack_dly(ACK_DLY), .open_req(OPEN_REQ), .frame_ack(FRAME_ACK),
      .remote_sabm(REMOTE_SABM));
   // Clock of 40 ns
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      exp_q.push_back({wr, e});
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Wait for the slave; only the hang guard ends a lost answer
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      `CHK(PREADY, 1'b1)
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] v);
      apb(1'b1, LMC_CTRL_ADDR, {24'h0, v}, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask
   // ****************************************
   // Output checks
   // ****************************************
   // Gating outputs one edge after the write
   task automatic gate(input logic md, input logic rb);
      logic [4:0] x;
      @(posedge CLK);
      #1;
      x = {md, !md, !md, DMA_REQ & !md, !md & rb};
      `CHK({LINK_DISC, TX_EN, RX_EN, DMA_REQ_OUT, IFRAME_RX_EN}, x)
   endtask
   // Random serial and DMA traffic, receive path source checked
   task automatic ser(input logic lp, input logic md);
      logic [3:0] t;
      logic [1:0] x;
      repeat (8) begin
         t = 4'($urandom);
         @(posedge CLK);
         TXD_IN <= t[0];
         RXD_PIN <= t[1];
         TX_BIT_EN <= t[2];
         RXC_PIN <= t[3];
         DMA_REQ <= ^t;
         @(posedge CLK);
         #1;
         x = lp ? {t[0], t[2]} : {t[1], t[3]};
         `CHK({RX_DATA, RX_BIT_EN}, x)
         `CHK(DMA_REQ_OUT, ^t & !md)
      end
   endtask
   // Bounded wait for the link to come up
   task automatic wait_up();
      int n;
      n = 0;
      while (LINK_UP !== 1'b1 && n < 60) begin
         @(posedge CLK);
         n++;
      end
      #1;
      `CHK(LINK_UP, 1'b1)
   endtask
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // Monitor: frame requests and bus answers
   // ****************************************
   always @(posedge CLK) begin
      logic [33:0] e;
      if (SEND_DISC === 1'b1) lg = {lg[5:0], 2'b10};
      if (SEND_SABM === 1'b1) lg = {lg[5:0], 2'b11};
      if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[33]) `CHK(PSLVERR, e[32])
         else `CHK({PSLVERR, PRDATA}, e[32:0])
      end
   end
   // Hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc > 4000) begin
         mismatches++;
         stop_test();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(12299));
      repeat (4) @(posedge CLK);
      RST_N <= 1'b1;
      gate(1'b1, 1'b0);
      rd(LMC_CTRL_ADDR, 33'h01);
      // Loopback set only while disconnected, address fields outside this block
      wr(8'hFF);
      gate(1'b1, 1'b1);
      `CHK({REG_TEST, HALF_DUPLEX}, 2'b11)
      ser(1'b1, 1'b1);
      rd(LMC_CTRL_ADDR, 33'hBF);
      rd(LMC_STAT_ADDR, 33'h01);
      // Refused accesses leave the control word alone
      rd(12'h010, 33'h1_0000_0000);
      apb(1'b1, LMC_STAT_ADDR, 32'h0, 33'h1_0000_0000);
      apb(1'b1, 12'h010, 32'h0, 33'h1_0000_0000);
      rd(LMC_CTRL_ADDR, 33'hBF);
      // Passive, receiver first not ready
      wr(8'h04);
      gate(1'b0, 1'b0);
      `CHK({REG_TEST, HALF_DUPLEX}, 2'b10)
      ser(1'b0, 1'b0);
      wr(8'h06);
      gate(1'b0, 1'b1);
      rd(LMC_STAT_ADDR, 33'h20);
      `CHK(lg, 8'h00)
      @(posedge CLK) OPEN_REQ <= 1'b1;
      @(posedge CLK) OPEN_REQ <= 1'b0;
      wait_up();
      rd(LMC_STAT_ADDR, 33'h140);
      // Active setup with, then without, the disconnect exchange
      for (int i = 0; i < 2; i++) begin
         wr(8'h01);
         gate(1'b1, 1'b0);
         `CHK(LINK_UP, 1'b0)
         lg = 8'h00;
         ACK_DLY <= 4'($urandom_range(7));
         wr(i ? 8'h90 : 8'h10);
         wait_up();
         `CHK(lg, i ? 8'h03 : 8'h0B)
      end
      stop_test();
   end
endmodule
